// ==== hw/fds_array.sv ====
// Data memory array of 1024 four-byte pages with page and byte access
module fds_array
    import fds_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rst,
    input  wire logic     i_go,
    input  wire fds_req_t i_req,
    input  wire logic     i_finish,
    output fds_rsp_t      o_rsp
);
    logic [31:0]        mem [PAGES];
    logic [PAGE_AW-1:0] page;
    logic [1:0]         lane;
    fds_req_t           hold_q;
    logic               clr_q;
    logic [PAGE_AW:0]   clr_idx_q;
    fds_rsp_t           rsp_q;

    assign page = hold_q.addr[BYTE_AW-1:2];
    assign lane = hold_q.addr[1:0];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hold_q <= '0;
        end else if (i_go) begin
            hold_q <= i_req;
        end
    end

    // Power-on contents are erased by a sweep rather than a reset of the array
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            clr_q     <= 1'b1;
            clr_idx_q <= '0;
        end else if (clr_q) begin
            clr_idx_q <= clr_idx_q + 1'b1;
            if (clr_idx_q == (PAGE_AW+1)'(PAGES - 1)) begin
                clr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (clr_q) begin
            mem[clr_idx_q[PAGE_AW-1:0]] <= {4{ERASED_BYTE}};
        end else if (i_finish) begin
            case (hold_q.op)
                OP_ERASE: mem[page] <= {4{ERASED_BYTE}}; // RL5 RL6
                OP_EALL: begin
                    for (int p = 0; p < PAGES; p++) begin
                        mem[p] <= {4{ERASED_BYTE}}; // RL10
                    end
                end
                // Programming can only pull bits low, as on real cells
                OP_WRITE: mem[page] <= mem[page] & hold_q.data; // RL7
                OP_WRB: mem[page][lane*8 +: 8] <= mem[page][lane*8 +: 8]
                                                & hold_q.data[7:0]; // RL18
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.done  <= i_finish;
            rsp_q.match <= (mem[page] == hold_q.data); // RL8
            case (hold_q.op)
                OP_RDB:  rsp_q.data <= {24'h0, mem[page][lane*8 +: 8]};
                default: rsp_q.data <= mem[page];
            endcase
        end
    end

    assign o_rsp = rsp_q;
endmodule

// ==== hw/fds_pkg.sv ====
// Shared constants, commands and carriers for the flash data memory sequencer
package fds_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CMD   = 3'h0;
    localparam logic [2:0] ADDR_ADRH  = 3'h1;
    localparam logic [2:0] ADDR_ADRL  = 3'h2;
    localparam logic [2:0] ADDR_DAT1  = 3'h3;
    localparam logic [2:0] ADDR_DAT2  = 3'h4;
    localparam logic [2:0] ADDR_DAT3  = 3'h5;
    localparam logic [2:0] ADDR_DAT4  = 3'h6;

    // Command codes
    localparam logic [7:0] CMD_READ      = 8'h01;
    localparam logic [7:0] CMD_WRITE     = 8'h02;
    localparam logic [7:0] CMD_VERIFY    = 8'h04;
    localparam logic [7:0] CMD_ERASE_PG  = 8'h05;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
    localparam logic [7:0] CMD_RD_BYTE   = 8'h81;
    localparam logic [7:0] CMD_WR_BYTE   = 8'h82;
    localparam logic [7:0] CMD_EXIT_PM   = 8'h0F;
    localparam logic [7:0] CMD_ENTER_PM  = 8'hF0;

    localparam logic [7:0] ERASED_BYTE   = 8'hFF;
    localparam logic [7:0] VERIFY_FAIL   = 8'h01;
    localparam logic [7:0] RST_BYTE      = 8'h00;

    localparam int PAGES      = 1024;
    localparam int PAGE_AW    = 10;
    localparam int BYTE_AW    = 12;

    // Operation times
    localparam int CLK_HZ        = 50_000_000;
    localparam int T_ERASE_US    = 2000;
    localparam int T_PGWRITE_US  = 15000;
    localparam int T_BYTEWR_US   = 200;
    localparam int T_READ_CYC    = 1;
    localparam int CYC_ERASE     = (T_ERASE_US * (CLK_HZ / 1_000_000));
    localparam int CYC_PGWRITE   = (T_PGWRITE_US * (CLK_HZ / 1_000_000));
    localparam int CYC_BYTEWR    = (T_BYTEWR_US * (CLK_HZ / 1_000_000));

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_READ  = 3'b001,
        OP_WRITE = 3'b010,
        OP_ERASE = 3'b011,
        OP_EALL  = 3'b100,
        OP_RDB   = 3'b101,
        OP_WRB   = 3'b110,
        OP_VER   = 3'b111
    } fds_op_t;

    typedef struct packed {
        fds_op_t               op;
        logic [BYTE_AW-1:0]    addr;
        logic [31:0]           data;
    } fds_req_t;

    typedef struct packed {
        logic                  done;
        logic                  match;
        logic [31:0]           data;
    } fds_rsp_t;

endpackage

// ==== hw/fds_timer.sv ====
// Busy timer that counts an operation's duration in clock cycles
module fds_timer
    import fds_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [31:0] i_cycles,
    output logic             o_done
);
    logic [31:0] cnt_q;
    logic        run_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 32'h0;
            run_q <= 1'b0;
        end else if (i_start) begin
            cnt_q <= i_cycles;
            run_q <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 32'h1;
            if (cnt_q <= 32'h1) begin
                run_q <= 1'b0;
            end
        end
    end

    assign o_done = run_q && (cnt_q <= 32'h1);
endmodule

// ==== hw/fds_top.sv ====
// Command sequencer for the on-chip flash data memory
// Notes on behaviour
// [RL1] Software loads address, data, then command
// [RL2] Code 1 reads addressed page into data
// [RL3] Byte change: read, patch, erase, write back
// [RL4] Program only erased bytes; erase first
// [RL5] Erase acts on whole four-byte pages
// [RL6] Code 5 erases the addressed page
// [RL7] Code 2 programs data into page
// [RL8] Code 4 verifies; command reads zero on match
// [RL9] Software treats nonzero verify as failure
// [RL10] Code 06H erases whole array, 2 ms
// [RL11] Setup code should issue full erase
// [RL12] Program memory mode typical times apply
// [RL13] Operation starts on command write cycle
// [RL14] Core held until operation finishes
// [RL15] No interrupts while busy; timers run
// [RL16] Hold from acceptance, released in one cycle
// [RL17] 1024 pages selected by address registers
// [RL18] 81H reads byte, 82H programs byte
// [RL19] F0H enters, 0FH leaves program memory mode
module fds_top
    import fds_pkg::*;
(
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST,
    input  wire logic [2:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic [7:0]      O_RDATA,
    output logic            O_CORE_HOLD,
    output logic            O_IRQ_BLOCK,
    output logic            O_PM_MODE,
    output logic            O_PM_REQ,
    output logic [7:0]      O_PM_CMD
);
    import fds_pkg::*;

    logic [7:0]  cmd_q;
    logic [7:0]  adrh_q;
    logic [7:0]  adrl_q;
    logic [7:0]  dat_q [4];
    logic [7:0]  rdata_q;
    logic        busy_q;
    logic        pm_mode_q;
    logic        pm_req_q;
    logic [7:0]  pm_cmd_q;
    logic        start;
    logic        cmd_wr;
    logic        timer_done;
    logic [31:0] cycles;
    fds_op_t     op;
    fds_op_t     op_q;
    fds_req_t    req;
    fds_rsp_t    rsp;

    assign cmd_wr = I_WR && (I_ADDR == ADDR_CMD) && !busy_q;

    always_comb begin
        op = OP_NONE;
        case (I_WDATA)
            CMD_READ:      op = OP_READ;
            CMD_WRITE:     op = OP_WRITE;
            CMD_VERIFY:    op = OP_VER;
            CMD_ERASE_PG:  op = OP_ERASE;
            CMD_ERASE_ALL: op = OP_EALL;
            CMD_RD_BYTE:   op = OP_RDB;
            CMD_WR_BYTE:   op = OP_WRB;
            default:       op = OP_NONE;
        endcase
    end

    // Data array commands only while not redirected to program memory
    assign start = cmd_wr && !pm_mode_q && (op != OP_NONE); // RL13

    always_comb begin
        cycles = 32'(T_READ_CYC);
        case (op)
            OP_ERASE: cycles = 32'(CYC_ERASE);
            OP_EALL:  cycles = 32'(CYC_ERASE); // RL10
            OP_WRITE: cycles = 32'(CYC_BYTEWR);
            OP_WRB:   cycles = 32'(CYC_BYTEWR);
            default:  cycles = 32'(T_READ_CYC);
        endcase
    end

    // Page commands take the page number; byte commands the full byte address
    always_comb begin
        req.op   = op;
        req.data = {dat_q[3], dat_q[2], dat_q[1], dat_q[0]};
        if (op == OP_RDB || op == OP_WRB) begin
            req.addr = {adrh_q[3:0], adrl_q}; // RL18
        end else begin
            req.addr = {adrh_q[1:0], adrl_q, 2'b00}; // RL17
        end
    end

    fds_timer u_timer (
        .i_clk    (I_SYS_CLK),
        .i_rst    (I_RST),
        .i_start  (start),
        .i_cycles (cycles),
        .o_done   (timer_done)
    );

    fds_array u_array (
        .i_clk    (I_SYS_CLK),
        .i_rst    (I_RST),
        .i_go     (start),
        .i_req    (req),
        .i_finish (timer_done),
        .o_rsp    (rsp)
    );

    // Busy until the array reports done, then one cycle to release
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            busy_q <= 1'b0;
            op_q   <= OP_NONE;
        end else if (start) begin
            busy_q <= 1'b1; // RL14 RL16
            op_q   <= op;
        end else if (rsp.done) begin
            busy_q <= 1'b0; // RL16
        end
    end

    assign O_CORE_HOLD = busy_q; // RL14
    assign O_IRQ_BLOCK = busy_q; // RL15

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            pm_mode_q <= 1'b0;
        end else if (cmd_wr && I_WDATA == CMD_ENTER_PM) begin
            pm_mode_q <= 1'b1; // RL19
        end else if (cmd_wr && I_WDATA == CMD_EXIT_PM) begin
            pm_mode_q <= 1'b0; // RL19
        end
    end

    // Program memory itself lives elsewhere; its commands are forwarded
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            pm_req_q <= 1'b0;
            pm_cmd_q <= RST_BYTE;
        end else begin
            pm_req_q <= cmd_wr && pm_mode_q && (I_WDATA != CMD_EXIT_PM); // RL12
            if (cmd_wr && pm_mode_q) begin
                pm_cmd_q <= I_WDATA;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            cmd_q <= RST_BYTE;
        end else if (busy_q && rsp.done && op_q == OP_VER) begin
            cmd_q <= rsp.match ? RST_BYTE : VERIFY_FAIL; // RL8
        end else if (cmd_wr) begin
            cmd_q <= I_WDATA;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            adrh_q <= RST_BYTE;
            adrl_q <= RST_BYTE;
        end else if (I_WR && !busy_q) begin
            if (I_ADDR == ADDR_ADRH) begin
                adrh_q <= I_WDATA;
            end
            if (I_ADDR == ADDR_ADRL) begin
                adrl_q <= I_WDATA;
            end
        end
    end

    generate
        for (genvar b = 0; b < 4; b++) begin : g_dat
            always_ff @(posedge I_SYS_CLK) begin
                if (I_RST) begin
                    dat_q[b] <= RST_BYTE;
                end else if (busy_q && rsp.done && op_q == OP_READ) begin
                    dat_q[b] <= rsp.data[b*8 +: 8]; // RL2
                end else if (busy_q && rsp.done && op_q == OP_RDB && b == 0) begin
                    dat_q[b] <= rsp.data[7:0]; // RL18
                end else if (I_WR && !busy_q && I_ADDR == 3'(ADDR_DAT1 + b)) begin
                    dat_q[b] <= I_WDATA;
                end
            end
        end
    endgenerate

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rdata_q <= RST_BYTE;
        end else if (I_RD) begin
            case (I_ADDR)
                ADDR_CMD:  rdata_q <= cmd_q;
                ADDR_ADRH: rdata_q <= adrh_q;
                ADDR_ADRL: rdata_q <= adrl_q;
                ADDR_DAT1: rdata_q <= dat_q[0];
                ADDR_DAT2: rdata_q <= dat_q[1];
                ADDR_DAT3: rdata_q <= dat_q[2];
                ADDR_DAT4: rdata_q <= dat_q[3];
                default:   rdata_q <= RST_BYTE;
            endcase
        end else begin
            rdata_q <= RST_BYTE;
        end
    end

    assign O_RDATA   = rdata_q;
    assign O_PM_MODE = pm_mode_q;
    assign O_PM_REQ  = pm_req_q;
    assign O_PM_CMD  = pm_cmd_q;
endmodule

// ==== verification/fds_core_model.sv ====
// Behavioural core that reads and writes the sequencer registers
module fds_core_model (
    input  wire logic       i_clk,
    input  wire logic       i_hold,
    input  wire logic [7:0] i_rdata,
    output logic [2:0]      o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_addr = 3'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Idle lines show inverted data so stale values never pass
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input bit late);
        @(posedge i_clk);
        while (i_hold === 1'b1 && !late) @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge i_clk);
        while (i_hold === 1'b1) @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        v = i_rdata;
    endtask
endmodule

// ==== verification/fds_monitor.sv ====
// Port checker for the flash data memory sequencer
module fds_monitor (
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST,
    input  wire logic [2:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    input  wire logic [7:0] O_RDATA,
    input  wire logic       O_CORE_HOLD,
    input  wire logic       O_IRQ_BLOCK,
    input  wire logic       O_PM_MODE,
    input  wire logic       O_PM_REQ
);
    import fds_pkg::*;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    logic cmd_wr;
    // Writes while busy are dropped, so only idle ones count
    assign cmd_wr = I_WR && I_ADDR == ADDR_CMD && !O_CORE_HOLD;
    property p_irq;
        O_IRQ_BLOCK == O_CORE_HOLD;
    endproperty
    a_irq: assert property (p_irq) else $error("irq block differs from hold");
    property p_rd_idle;
        !I_RD |=> O_RDATA == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_unmap;
        I_RD && I_ADDR == 3'h7 |=> O_RDATA == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_write;
        cmd_wr && !O_PM_MODE && I_WDATA == CMD_WRITE |=> O_CORE_HOLD [*8];
    endproperty
    a_write: assert property (p_write) else $error("page write hold missing");
    property p_erase_pg;
        cmd_wr && !O_PM_MODE && I_WDATA == CMD_ERASE_PG |=> O_CORE_HOLD [*8];
    endproperty
    a_erase_pg: assert property (p_erase_pg) else $error("page erase hold missing");
    property p_erase_all;
        cmd_wr && !O_PM_MODE && I_WDATA == CMD_ERASE_ALL |=> O_CORE_HOLD [*8];
    endproperty
    a_erase_all: assert property (p_erase_all) else $error("full erase hold missing");
    property p_read;
        cmd_wr && !O_PM_MODE && (I_WDATA == CMD_READ || I_WDATA == CMD_VERIFY)
            |=> O_CORE_HOLD ##1 O_CORE_HOLD ##1 !O_CORE_HOLD;
    endproperty
    a_read: assert property (p_read) else $error("read hold wrong length");
    property p_unknown;
        cmd_wr && I_WDATA == 8'h03 |=> !O_CORE_HOLD [*4];
    endproperty
    a_unknown: assert property (p_unknown) else $error("reserved code started work");
    property p_pm_on;
        cmd_wr && !O_PM_MODE && I_WDATA == CMD_ENTER_PM |=> ##[0:1] O_PM_MODE;
    endproperty
    a_pm_on: assert property (p_pm_on) else $error("mode entry missed");
    property p_pm_fwd;
        cmd_wr && O_PM_MODE && I_WDATA == CMD_READ |=> ##[0:1] O_PM_REQ && !O_CORE_HOLD;
    endproperty
    a_pm_fwd: assert property (p_pm_fwd) else $error("command not forwarded");
    property p_pm_off;
        cmd_wr && O_PM_MODE && I_WDATA == CMD_EXIT_PM |=> ##[0:1] !O_PM_MODE;
    endproperty
    a_pm_off: assert property (p_pm_off) else $error("mode exit missed");
    property p_req_pulse;
        O_PM_REQ |=> !O_PM_REQ;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("forward pulse too long");
endmodule

bind fds_top fds_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_CORE_HOLD(O_CORE_HOLD), .O_IRQ_BLOCK(O_IRQ_BLOCK), .O_PM_MODE(O_PM_MODE),
    .O_PM_REQ(O_PM_REQ));

// ==== verification/tb.sv ====
// Self-checking bench for the flash data memory sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fds_pkg::*;
    logic       clk;
    logic       rst = 1'b1;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       hold;
    logic       pm_mode;
    logic       pm_req;
    logic [7:0] pm_cmd;
    logic [7:0] v;
    logic [7:0] seen_req = 8'h00;
    int         num_errors = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         hold_n = 0;

    fds_top u_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_CORE_HOLD(hold), .O_IRQ_BLOCK(),
        .O_PM_MODE(pm_mode), .O_PM_REQ(pm_req), .O_PM_CMD(pm_cmd));
    fds_core_model u_core (.i_clk(clk), .i_hold(hold), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pm_req === 1'b1) seen_req <= 8'h01;
        if (cycles == 130000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        u_core.rd(a, v);
        chk(v, exp);
    endtask
    task automatic rd4(input logic [31:0] exp);
        for (int i = 0; i < 4; i++) rdc(ADDR_DAT1 + 3'(i), exp[31-8*i -: 8]);
    endtask
    task automatic ld(input logic [7:0] l, input logic [31:0] d);
        u_core.wr(ADDR_ADRH, 8'h00, 1'b0);
        u_core.wr(ADDR_ADRL, l, 1'b0);
        for (int i = 0; i < 4; i++) u_core.wr(ADDR_DAT1 + 3'(i), d[31-8*i -: 8], 1'b0);
    endtask
    // Optional late write lands while busy and must be dropped
    task automatic cmd(input logic [7:0] code, input bit late);
        int n;
        n = 0;
        u_core.wr(ADDR_CMD, code, 1'b0);
        if (late) u_core.wr(ADDR_DAT1, 8'h00, 1'b1);
        @(posedge clk);
        #1;
        while (hold === 1'b1 && n < 110000) begin
            @(posedge clk);
            #1;
            n++;
        end
        hold_n = n;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Array sweeps itself to erased after reset
        repeat (1040) @(posedge clk);
        ld(8'h0D, 32'h5A000000);
        cmd(CMD_WR_BYTE, 1'b0);
        ld(8'h0D, 32'h00000000);
        cmd(CMD_RD_BYTE, 1'b0);
        rdc(ADDR_DAT1, 8'h5A);
        ld(8'h03, 32'h00000000);
        cmd(CMD_READ, 1'b0);
        rd4(32'hFF5AFFFF);
        cmd(CMD_VERIFY, 1'b0);
        rdc(ADDR_CMD, 8'h00);
        u_core.wr(ADDR_DAT2, 8'hF3, 1'b0);
        cmd(CMD_VERIFY, 1'b0);
        u_core.rd(ADDR_CMD, v);
        chk(8'(v != 8'h00), 8'h01);
        // Byte 2 holds 5A, so the write back only matches after a real erase
        cmd(CMD_ERASE_PG, 1'b0);
        chk(8'(hold_n == CYC_ERASE), 8'h01);
        cmd(CMD_WRITE, 1'b1);
        rdc(ADDR_DAT1, 8'hFF);
        cmd(CMD_VERIFY, 1'b0);
        rdc(ADDR_CMD, 8'h00);
        ld(8'h03, 32'h00000000);
        cmd(CMD_READ, 1'b0);
        rd4(32'hFFF3FFFF);
        cmd(8'h03, 1'b0);
        rdc(ADDR_CMD, 8'h03);
        cmd(CMD_ENTER_PM, 1'b0);
        chk({7'h00, pm_mode}, 8'h01);
        cmd(CMD_READ, 1'b0);
        chk(pm_cmd, CMD_READ);
        chk(seen_req, 8'h01);
        cmd(CMD_EXIT_PM, 1'b0);
        chk({7'h00, pm_mode}, 8'h00);
        u_core.wr(ADDR_CMD, CMD_ERASE_ALL, 1'b0);
        repeat (9) @(posedge clk);
        #1;
        chk({7'h00, hold}, 8'h01);
        // Full erase is too long to wait out; a reset in mid-run abandons it
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({7'h00, hold}, 8'h00);
        rdc(ADDR_CMD, 8'h00);
        repeat (1040) @(posedge clk);
        ld(8'h03, 32'h00000000);
        cmd(CMD_READ, 1'b0);
        rd4(32'hFFFFFFFF);
        rdc(3'h7, 8'h00);
        tally_and_finish();
    end
endmodule
